// ### hdl/ufc_fifo_mem.v
// sixteen-entry character store with one write and one registered read port
// assumes the caller keeps its own pointers; write-through covers a same-cycle
// write to the address being read
`timescale 1ns/1ps

module ufc_fifo_mem #(
	parameter DATA_W = 8
) (
	input  wire              clk_i,
	input  wire              rst_n_i,
	input  wire              ce_i,
	input  wire              we_i,
	input  wire [3:0]        waddr_i,
	input  wire [DATA_W-1:0] wdata_i,
	input  wire [3:0]        raddr_i,
	output wire [DATA_W-1:0] rdata_o
);

	reg [DATA_W-1:0] mem_ff [0:15];
	reg [DATA_W-1:0] rdata_ff;

	// ----------------------------------------------------------------
	// storage array, no reset needed since reads are guarded by counts
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (ce_i && we_i) begin
			mem_ff[waddr_i] <= wdata_i;
		end
	end

	// registered read; bypass so a fresh head is never stale
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_ff <= {DATA_W{1'b0}};
		end else if (ce_i) begin
			if (we_i && (waddr_i == raddr_i)) begin
				rdata_ff <= wdata_i;
			end else begin
				rdata_ff <= mem_ff[raddr_i];
			end
		end
	end

	assign rdata_o = rdata_ff;

endmodule // ufc_fifo_mem

// ### hdl/ufc_regs.vh
// register offsets, field positions, reset values and sizes of the
// uart fifo control block; definitions only, included by bare name
`ifndef UFC_REGS_VH
`define UFC_REGS_VH

// ----------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------
`define UFC_OFS_DATA      4'h0
`define UFC_OFS_RX_ERR    4'h1
`define UFC_OFS_FIFO_CTRL 4'h2
`define UFC_OFS_ALT_FUNC  4'h3
`define UFC_OFS_TX_LEVEL  4'h4
`define UFC_OFS_RX_LEVEL  4'h5
`define UFC_OFS_STATUS    4'h6

// ----------------------------------------------------------------
// fifo_control fields
// ----------------------------------------------------------------
`define UFC_FC_ENABLE   0
`define UFC_FC_RX_FLUSH 1
`define UFC_FC_TX_FLUSH 2
`define UFC_FC_DMA_MODE 3
`define UFC_FC_TRIG_LO  6
`define UFC_FC_TRIG_HI  7
`define UFC_FC_RESET    8'h00
`define UFC_FC_KEEP     8'hc9

// ----------------------------------------------------------------
// alternate_function_reg fields
// ----------------------------------------------------------------
`define UFC_AF_MF_LO    1
`define UFC_AF_MF_HI    2
`define UFC_AF_MF_RX_DMA_REQUEST 2'h1
`define UFC_AF_RESET    8'h00
`define UFC_AF_KEEP     8'h06

// ----------------------------------------------------------------
// receive trigger levels and fifo sizes
// ----------------------------------------------------------------
`define UFC_TRIG_SEL0 5'h01
`define UFC_TRIG_SEL1 5'h04
`define UFC_TRIG_SEL2 5'h08
`define UFC_TRIG_SEL3 5'h0e
`define UFC_DEPTH     5'h10
`define UFC_ONE_CHAR  5'h01
`define UFC_CHAR_W    8
`define UFC_ERR_W     3
`define UFC_RX_W      11

`endif

// ### hdl/ufc_top.v
// fifo control of one uart channel: transmit and receive fifos, flush,
// receive trigger level and the two dma request signalling modes
// assumes a transmit shifter that pops on tx_pop_i while tx_valid_o is high,
// and a receiver that pushes characters with their error flags
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`include "ufc_regs.vh"

// Function
// - trigger field picks receive fill level
// - trigger codes give 1, 4, 8, 14
// - receive fifo fills on past trigger
// - control bits five, four read zero
// - bit three picks dma mode, resets 0
// - mode 0 tx request low when empty
// - mode 0 tx request high on write
// - mode 0 rx request low when data
// - mode 0 rx request high when empty
// - pin shows rx request when selected
// - mode 1 tx request high when full
// - mode 1 tx request low when space
// - mode 1 rx request low on trigger/timeout
// - mode 1 rx request high when emptied
// - bit two flushes tx fifo, self-clears
// - bit one flushes rx fifo, self-clears
// - bit zero enables fifos, resets 0
module ufc_top (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire        ce_i,
	input  wire [3:0]  addr_i,
	input  wire [7:0]  wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output wire [7:0]  rdata_o,
	output wire [7:0]  tx_data_o,
	output wire        tx_valid_o,
	input  wire        tx_pop_i,
	input  wire [7:0]  rx_data_i,
	input  wire [2:0]  rx_err_i,
	input  wire        rx_push_i,
	input  wire        rx_timeout_i,
	output wire        rx_trigger_o,
	output wire        tx_dma_request_n_o,
	output wire        multi_function_pin_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg  [7:0]  fifo_control_ff;
	reg  [7:0]  alt_func_ff;
	reg  [4:0]  tx_cnt_ff;
	reg  [3:0]  tx_wr_ptr_ff;
	reg  [3:0]  tx_rd_ptr_ff;
	reg  [4:0]  rx_cnt_ff;
	reg  [3:0]  rx_wr_ptr_ff;
	reg  [3:0]  rx_rd_ptr_ff;
	reg         rx_act_ff;
	reg         rx_overrun_ff;
	reg  [7:0]  rdata_ff;
	reg         tx_valid_ff;
	reg         rx_trigger_ff;
	reg         tx_req_n_ff;
	reg         mf_pin_ff;

	reg  [7:0]  nxt_fifo_control;
	reg  [4:0]  nxt_tx_cnt;
	reg  [3:0]  nxt_tx_rd_ptr;
	reg  [4:0]  nxt_rx_cnt;
	reg  [3:0]  nxt_rx_rd_ptr;
	reg         nxt_rx_act;
	reg  [4:0]  trig_level;
	reg  [7:0]  nxt_rdata;
	reg         dec_data;
	reg         dec_err;
	reg         dec_fc;
	reg         dec_af;
	reg         dec_txl;
	reg         dec_rxl;
	reg         dec_stat;

	wire        fifo_en;
	wire        mode1;
	wire [4:0]  cap;
	wire        fc_wr;
	wire        mode_flip;
	wire        tx_flush;
	wire        rx_flush;
	wire        tx_push;
	wire        tx_pop;
	wire        rx_push;
	wire        rx_pop;
	wire        nxt_rx_trig;
	wire        nxt_tx_req_n;
	wire        nxt_rx_req_n;
	wire [10:0] rx_head;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	always @* begin
		dec_data = 1'b0;
		dec_err  = 1'b0;
		dec_fc   = 1'b0;
		dec_af   = 1'b0;
		dec_txl  = 1'b0;
		dec_rxl  = 1'b0;
		dec_stat = 1'b0;
		if (addr_i == `UFC_OFS_DATA) begin
			dec_data = 1'b1;
		end else if (addr_i == `UFC_OFS_RX_ERR) begin
			dec_err = 1'b1;
		end else if (addr_i == `UFC_OFS_FIFO_CTRL) begin
			dec_fc = 1'b1;
		end else if (addr_i == `UFC_OFS_ALT_FUNC) begin
			dec_af = 1'b1;
		end else if (addr_i == `UFC_OFS_TX_LEVEL) begin
			dec_txl = 1'b1;
		end else if (addr_i == `UFC_OFS_RX_LEVEL) begin
			dec_rxl = 1'b1;
		end else if (addr_i == `UFC_OFS_STATUS) begin
			dec_stat = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// fifo control register
	// ----------------------------------------------------------------
	assign fc_wr   = wr_i & dec_fc;
	assign fifo_en = fifo_control_ff[`UFC_FC_ENABLE];
	assign mode1   = fifo_en & fifo_control_ff[`UFC_FC_DMA_MODE];

	// without the enable bit only the enable itself is taken
	always @* begin
		nxt_fifo_control = fifo_control_ff;
		if (fc_wr) begin
			if (wdata_i[`UFC_FC_ENABLE]) begin
				nxt_fifo_control = wdata_i & `UFC_FC_KEEP;
			end else begin
				nxt_fifo_control[`UFC_FC_ENABLE] = 1'b0;
			end
		end
	end

	// flush bits act as pulses and are never stored, so they read back zero;
	// switching between fifo and single-character operation also flushes,
	// since stale pointers would otherwise cross the capacity change
	assign mode_flip = fc_wr & (wdata_i[`UFC_FC_ENABLE] != fifo_en);
	assign tx_flush  = (fc_wr & wdata_i[`UFC_FC_ENABLE] &
		wdata_i[`UFC_FC_TX_FLUSH]) | mode_flip;
	assign rx_flush  = (fc_wr & wdata_i[`UFC_FC_ENABLE] &
		wdata_i[`UFC_FC_RX_FLUSH]) | mode_flip;

	// single-character operation keeps one slot, fifo operation sixteen
	assign cap = fifo_en ? `UFC_DEPTH : `UFC_ONE_CHAR;

	// ----------------------------------------------------------------
	// receive trigger level
	// ----------------------------------------------------------------
	always @* begin
		case (fifo_control_ff[`UFC_FC_TRIG_HI:`UFC_FC_TRIG_LO])
			2'h0: trig_level = `UFC_TRIG_SEL0;
			2'h1: trig_level = `UFC_TRIG_SEL1;
			2'h2: trig_level = `UFC_TRIG_SEL2;
			default: trig_level = `UFC_TRIG_SEL3;
		endcase
	end

	// ----------------------------------------------------------------
	// transmit fifo bookkeeping
	// ----------------------------------------------------------------
	// a write when full is dropped; the holding slot is the fifo itself
	assign tx_push = wr_i & dec_data & (tx_cnt_ff < cap);
	assign tx_pop  = tx_pop_i & (tx_cnt_ff != 5'h00);

	// flush clears pointers and count only; the shifter keeps its character
	always @* begin
		nxt_tx_cnt    = tx_cnt_ff;
		nxt_tx_rd_ptr = tx_rd_ptr_ff;
		if (tx_flush) begin
			nxt_tx_cnt    = 5'h00;
			nxt_tx_rd_ptr = 4'h0;
		end else begin
			if (tx_pop) begin
				nxt_tx_rd_ptr = tx_rd_ptr_ff + 4'h1;
			end
			if (tx_push && !tx_pop) begin
				nxt_tx_cnt = tx_cnt_ff + 5'h01;
			end else if (tx_pop && !tx_push) begin
				nxt_tx_cnt = tx_cnt_ff - 5'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// receive fifo bookkeeping
	// ----------------------------------------------------------------
	// accepted until every slot is used, whatever the trigger level
	assign rx_push = rx_push_i & (rx_cnt_ff < cap);
	assign rx_pop  = rd_i & dec_data & (rx_cnt_ff != 5'h00);

	always @* begin
		nxt_rx_cnt    = rx_cnt_ff;
		nxt_rx_rd_ptr = rx_rd_ptr_ff;
		if (rx_flush) begin
			nxt_rx_cnt    = 5'h00;
			nxt_rx_rd_ptr = 4'h0;
		end else begin
			if (rx_pop) begin
				nxt_rx_rd_ptr = rx_rd_ptr_ff + 4'h1;
			end
			if (rx_push && !rx_pop) begin
				nxt_rx_cnt = rx_cnt_ff + 5'h01;
			end else if (rx_pop && !rx_push) begin
				nxt_rx_cnt = rx_cnt_ff - 5'h01;
			end
		end
	end

	// raised once the count meets the level and held while above it
	assign nxt_rx_trig = fifo_en ? (nxt_rx_cnt >= trig_level) :
		(nxt_rx_cnt != 5'h00);

	// ----------------------------------------------------------------
	// dma request signalling
	// ----------------------------------------------------------------
	// mode 0 tx: low only while nothing waits; first write lifts it
	// mode 1 tx: high only when all sixteen slots are taken
	assign nxt_tx_req_n = mode1 ? (nxt_tx_cnt == `UFC_DEPTH) :
		(nxt_tx_cnt != 5'h00);

	// mode 1 rx latch: set on trigger or time-out, held until empty
	always @* begin
		nxt_rx_act = rx_act_ff;
		if (nxt_rx_cnt == 5'h00) begin
			nxt_rx_act = 1'b0;
		end else if (nxt_rx_trig || rx_timeout_i) begin
			nxt_rx_act = 1'b1;
		end
	end

	assign nxt_rx_req_n = mode1 ? ~nxt_rx_act :
		(nxt_rx_cnt == 5'h00);

	// ----------------------------------------------------------------
	// register read data, valid only in the cycle after the strobe
	// ----------------------------------------------------------------
	always @* begin
		nxt_rdata = 8'h00;
		if (rd_i) begin
			if (dec_data) begin
				nxt_rdata = (rx_cnt_ff != 5'h00) ? rx_head[7:0] : 8'h00;
			end else if (dec_err) begin
				nxt_rdata = (rx_cnt_ff != 5'h00) ?
					{5'h00, rx_head[10:8]} : 8'h00;
			end else if (dec_fc) begin
				nxt_rdata = fifo_control_ff;
			end else if (dec_af) begin
				nxt_rdata = alt_func_ff;
			end else if (dec_txl) begin
				nxt_rdata = {3'h0, tx_cnt_ff};
			end else if (dec_rxl) begin
				nxt_rdata = {3'h0, rx_cnt_ff};
			end else if (dec_stat) begin
				nxt_rdata = {2'h0, rx_overrun_ff, rx_trigger_ff,
					(rx_cnt_ff == cap), (tx_cnt_ff == cap),
					(tx_cnt_ff == 5'h00), (rx_cnt_ff != 5'h00)};
			end
		end
	end

	// ----------------------------------------------------------------
	// clocked state
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			fifo_control_ff <= `UFC_FC_RESET;
			alt_func_ff     <= `UFC_AF_RESET;
			tx_cnt_ff       <= 5'h00;
			tx_wr_ptr_ff    <= 4'h0;
			tx_rd_ptr_ff    <= 4'h0;
			rx_cnt_ff       <= 5'h00;
			rx_wr_ptr_ff    <= 4'h0;
			rx_rd_ptr_ff    <= 4'h0;
			rx_act_ff       <= 1'b0;
			rx_overrun_ff   <= 1'b0;
			rdata_ff        <= 8'h00;
			tx_valid_ff     <= 1'b0;
			rx_trigger_ff   <= 1'b0;
			tx_req_n_ff     <= 1'b0;
			mf_pin_ff       <= 1'b1;
		end else if (ce_i) begin
			fifo_control_ff <= nxt_fifo_control;
			if (wr_i && dec_af) begin
				alt_func_ff <= wdata_i & `UFC_AF_KEEP;
			end
			tx_cnt_ff    <= nxt_tx_cnt;
			tx_rd_ptr_ff <= nxt_tx_rd_ptr;
			if (tx_flush) begin
				tx_wr_ptr_ff <= 4'h0;
			end else if (tx_push) begin
				tx_wr_ptr_ff <= tx_wr_ptr_ff + 4'h1;
			end
			rx_cnt_ff    <= nxt_rx_cnt;
			rx_rd_ptr_ff <= nxt_rx_rd_ptr;
			if (rx_flush) begin
				rx_wr_ptr_ff <= 4'h0;
			end else if (rx_push) begin
				rx_wr_ptr_ff <= rx_wr_ptr_ff + 4'h1;
			end
			rx_act_ff <= nxt_rx_act;
			// a lost character in the clearing read's cycle still sets
			if (rx_push_i && !rx_push) begin
				rx_overrun_ff <= 1'b1;
			end else if (rd_i && dec_stat) begin
				rx_overrun_ff <= 1'b0;
			end
			rdata_ff      <= nxt_rdata;
			tx_valid_ff   <= (nxt_tx_cnt != 5'h00);
			rx_trigger_ff <= nxt_rx_trig;
			tx_req_n_ff   <= nxt_tx_req_n;
			// other pin functions lie outside this block; pin idles high
			if (alt_func_ff[`UFC_AF_MF_HI:`UFC_AF_MF_LO] == `UFC_AF_MF_RX_DMA_REQUEST) begin
				mf_pin_ff <= nxt_rx_req_n;
			end else begin
				mf_pin_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// character stores, read port aimed at the next head
	// ----------------------------------------------------------------
	ufc_fifo_mem #(
		.DATA_W (`UFC_CHAR_W)
	) u_tx_mem (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.ce_i    (ce_i),
		.we_i    (tx_push & ~tx_flush),
		.waddr_i (tx_wr_ptr_ff),
		.wdata_i (wdata_i),
		.raddr_i (nxt_tx_rd_ptr),
		.rdata_o (tx_data_o)
	);

	ufc_fifo_mem #(
		.DATA_W (`UFC_RX_W)
	) u_rx_mem (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.ce_i    (ce_i),
		.we_i    (rx_push & ~rx_flush),
		.waddr_i (rx_wr_ptr_ff),
		.wdata_i ({rx_err_i, rx_data_i}),
		.raddr_i (nxt_rx_rd_ptr),
		.rdata_o (rx_head)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rdata_o              = rdata_ff;
	assign tx_valid_o           = tx_valid_ff;
	assign rx_trigger_o         = rx_trigger_ff;
	assign tx_dma_request_n_o   = tx_req_n_ff;
	assign multi_function_pin_o = mf_pin_ff;

endmodule // ufc_top

// ### test/tb_top.sv
// self-checking bench for ufc_top with the line-side model and the port checker
// assumes a 20 MHz clock and the one-cycle strobe register bus
`timescale 1ns/1ps
`include "ufc_regs.vh"

module tb_top;
	reg        clk_i = 1'b0;
	reg        rst_n_i = 1'b0;
	reg  [3:0] addr_i = 4'h0;
	reg  [7:0] wdata_i = 8'h00;
	reg        wr_i = 1'b0;
	reg        rd_i = 1'b0;
	reg  [7:0] rv;
	integer    n_fail = 0;
	integer    compares = 0;
	integer    j;
	integer    k;
	wire [7:0] rdata_o, tx_data_o, rx_data_i;
	wire [2:0] rx_err_i;
	wire       tx_valid_o, tx_pop_i, rx_push_i, rx_timeout_i;
	wire       rx_trigger_o, tx_dma_request_n_o, multi_function_pin_o;
	// valid, trigger, tx request, pin
	wire [7:0] flags = {4'h0, tx_valid_o, rx_trigger_o, tx_dma_request_n_o, multi_function_pin_o};

	always #25 clk_i = ~clk_i;

	ufc_top ufc_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_data_o(tx_data_o),
		.tx_valid_o(tx_valid_o), .tx_pop_i(tx_pop_i), .rx_data_i(rx_data_i), .rx_err_i(rx_err_i),
		.rx_push_i(rx_push_i), .rx_timeout_i(rx_timeout_i), .rx_trigger_o(rx_trigger_o),
		.tx_dma_request_n_o(tx_dma_request_n_o), .multi_function_pin_o(multi_function_pin_o));
	ufc_line_model ufc_line_model_i (.clk_i(clk_i), .tx_valid_i(tx_valid_o), .tx_pop_o(tx_pop_i),
		.rx_data_o(rx_data_i), .rx_err_o(rx_err_i), .rx_push_o(rx_push_i),
		.rx_timeout_o(rx_timeout_i));

	task chk(input string nm, input [7:0] seen, input [7:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("wrong value %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask

	// bus cycles end just past the sampling edge, outputs settled
	task wr(input [3:0] a, input [7:0] d);
		begin
			@(posedge clk_i);
			addr_i <= a;
			wdata_i <= d;
			wr_i <= 1'b1;
			@(posedge clk_i);
			wr_i <= 1'b0;
			#1;
		end
	endtask

	task rd(input [3:0] a);
		begin
			@(posedge clk_i);
			addr_i <= a;
			rd_i <= 1'b1;
			@(posedge clk_i);
			rd_i <= 1'b0;
			#1;
			rv = rdata_o;
		end
	endtask

	task final_report;
		begin
			if (n_fail == 0 && compares > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask

	// single-character operation after reset
	task t_single;
		begin
			ufc_line_model_i.push(8'h5a, 3'h0);
			chk("pin unrouted", flags, 8'h05);
			wr(`UFC_OFS_ALT_FUNC, 8'h02);
			chk("pin one edge late", flags, 8'h05);
			@(posedge clk_i);
			#1;
			chk("rx request", flags, 8'h04);
			rd(`UFC_OFS_DATA);
			chk("rx char", rv, 8'h5a);
			chk("rx released", flags, 8'h01);
			wr(`UFC_OFS_DATA, 8'h33);
			chk("tx loaded", flags, 8'h0b);
			chk("tx char", tx_data_o, 8'h33);
			ufc_line_model_i.pop;
			chk("tx empty", flags, 8'h01);
			wr(`UFC_OFS_FIFO_CTRL, 8'hc8);
			rd(`UFC_OFS_FIFO_CTRL);
			chk("ignored ctrl", rv, 8'h00);
		end
	endtask

	// every trigger code in mode 1, filled past the level and drained
	task t_levels;
		integer lv;
		begin
			for (k = 0; k < 4; k = k + 1) begin
				lv = (k == 0) ? 1 : (k == 1) ? 4 : (k == 2) ? 8 : 14;
				wr(`UFC_OFS_FIFO_CTRL, {k[1:0], 6'h0b});
				for (j = 0; j < 17; j = j + 1) begin
					if (j == lv - 1) chk("below level", flags, 8'h01);
					if (j == lv) chk("at level", flags, 8'h04);
					ufc_line_model_i.push(8'h40 + j[7:0], ~j[2:0]);
				end
				rd(`UFC_OFS_RX_LEVEL);
				chk("rx count", rv, 8'h10);
				rd(`UFC_OFS_STATUS);
				chk("rx status", rv, 8'h3b);
				rd(`UFC_OFS_RX_ERR);
				chk("head flags", rv, 8'h07);
				for (j = 0; j < 16; j = j + 1) begin
					rd(`UFC_OFS_DATA);
					chk("rx order", rv, 8'h40 + j[7:0]);
					if (j == 14) chk("pin held", flags & 8'h01, 8'h00);
				end
				chk("drained", flags, 8'h01);
			end
		end
	endtask

	// mode 1 transmit fill, flushes, time-out and an unmapped read
	task t_tx_m1;
		begin
			wr(`UFC_OFS_FIFO_CTRL, 8'h09);
			for (j = 0; j < 16; j = j + 1) begin
				if (j == 15) chk("one free", flags, 8'h09);
				wr(`UFC_OFS_DATA, 8'h20 + j[7:0]);
			end
			chk("tx full", flags, 8'h0b);
			chk("tx head", tx_data_o, 8'h20);
			rd(`UFC_OFS_TX_LEVEL);
			chk("tx count", rv, 8'h10);
			wr(`UFC_OFS_FIFO_CTRL, 8'h0d);
			chk("tx flushed", flags, 8'h01);
			rd(`UFC_OFS_FIFO_CTRL);
			chk("self clear", rv, 8'h09);
			ufc_line_model_i.push(8'h11, 3'h1);
			ufc_line_model_i.push(8'h12, 3'h2);
			wr(`UFC_OFS_FIFO_CTRL, 8'h0b);
			rd(`UFC_OFS_RX_LEVEL);
			chk("rx flushed", rv, 8'h00);
			wr(`UFC_OFS_FIFO_CTRL, 8'hc9);
			ufc_line_model_i.push(8'h13, 3'h0);
			ufc_line_model_i.push(8'h14, 3'h0);
			chk("under level", flags, 8'h01);
			ufc_line_model_i.timeout;
			chk("timeout", flags, 8'h00);
			rd(`UFC_OFS_DATA);
			chk("one left", flags, 8'h00);
			rd(`UFC_OFS_DATA);
			chk("emptied", flags, 8'h01);
			rd(4'hf);
			chk("unmapped", rv, 8'h00);
			wr(`UFC_OFS_FIFO_CTRL, 8'h01);
			ufc_line_model_i.push(8'h15, 3'h0);
			chk("fifo mode 0 rx", flags, 8'h04);
			wr(`UFC_OFS_DATA, 8'h55);
			chk("fifo mode 0 tx", flags, 8'h0e);
		end
	endtask

	// a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail = n_fail + 1;
		final_report;
	end

	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		#1;
		chk("reset flags", flags, 8'h01);
		rd(`UFC_OFS_FIFO_CTRL);
		chk("reset ctrl", rv, 8'h00);
		t_single;
		t_levels;
		t_tx_m1;
		final_report;
	end
endmodule // tb_top

bind ufc_top ufc_top_checker ufc_top_checker_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.tx_valid_o(tx_valid_o), .tx_pop_i(tx_pop_i), .rx_push_i(rx_push_i),
	.rx_timeout_i(rx_timeout_i), .rx_trigger_o(rx_trigger_o),
	.tx_dma_request_n_o(tx_dma_request_n_o), .multi_function_pin_o(multi_function_pin_o));

// ### test/ufc_line_model.sv
// line-side stand-in: a transmit shifter that pops and a receiver that pushes
// assumes the fifo block samples these lines at the rising edge of clk_i
`timescale 1ns/1ps

module ufc_line_model (
	input  wire       clk_i,
	input  wire       tx_valid_i,
	output reg        tx_pop_o,
	output reg  [7:0] rx_data_o,
	output reg  [2:0] rx_err_o,
	output reg        rx_push_o,
	output reg        rx_timeout_o
);
	initial begin
		tx_pop_o = 1'b0;
		rx_data_o = 8'h00;
		rx_err_o = 3'h0;
		rx_push_o = 1'b0;
		rx_timeout_o = 1'b0;
	end

	// one character; afterwards the lines show the inverse so nothing stale looks valid
	task push(input [7:0] d, input [2:0] e);
		begin
			@(posedge clk_i);
			rx_data_o <= d;
			rx_err_o <= e;
			rx_push_o <= 1'b1;
			@(posedge clk_i);
			rx_push_o <= 1'b0;
			rx_data_o <= ~d;
			rx_err_o <= ~e;
			#1;
		end
	endtask

	// shifter takes the head only when there is one
	task pop;
		begin
			@(posedge clk_i);
			tx_pop_o <= tx_valid_i;
			@(posedge clk_i);
			tx_pop_o <= 1'b0;
			#1;
		end
	endtask

	task timeout;
		begin
			@(posedge clk_i);
			rx_timeout_o <= 1'b1;
			@(posedge clk_i);
			rx_timeout_o <= 1'b0;
			#1;
		end
	endtask
endmodule // ufc_line_model

// ### test/ufc_top_checker.sv
// port checker for ufc_top: fill counts and control state are shadowed from the ports
// assumes ce_i stays high and the one-cycle strobe register bus
`timescale 1ns/1ps
`include "ufc_regs.vh"

module ufc_top_checker (
	input wire       clk_i,
	input wire       rst_n_i,
	input wire       ce_i,
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i,
	input wire       wr_i,
	input wire       rd_i,
	input wire [7:0] rdata_o,
	input wire       tx_valid_o,
	input wire       tx_pop_i,
	input wire       rx_push_i,
	input wire       rx_timeout_i,
	input wire       rx_trigger_o,
	input wire       tx_dma_request_n_o,
	input wire       multi_function_pin_o
);
	// ----------------------------------------
	// shadow state
	// ----------------------------------------
	reg        en_ff;
	reg        mode_ff;
	reg        sel_ff;
	reg  [1:0] trig_ff;
	reg  [4:0] txc_ff;
	reg  [4:0] rxc_ff;
	reg  [4:0] lvl;
	reg        d_en_ff;
	reg        d_m1_ff;
	reg        d_sel_ff;
	reg  [4:0] d_lvl_ff;
	wire       fc_wr = wr_i && addr_i == `UFC_OFS_FIFO_CTRL;
	wire       fl_all = fc_wr && wdata_i[0] != en_ff;
	wire       fl_tx = fl_all || (fc_wr && wdata_i[0] && wdata_i[2]);
	wire       fl_rx = fl_all || (fc_wr && wdata_i[0] && wdata_i[1]);
	wire       m1 = en_ff && mode_ff;
	wire [4:0] cap = en_ff ? `UFC_DEPTH : `UFC_ONE_CHAR;
	wire       t_in = wr_i && addr_i == `UFC_OFS_DATA && txc_ff != cap;
	wire       t_out = tx_pop_i && txc_ff != 5'h00;
	wire       r_in = rx_push_i && rxc_ff != cap;
	wire       r_out = rd_i && addr_i == `UFC_OFS_DATA && rxc_ff != 5'h00;

	// trigger code to fill level
	always @* begin
		case (trig_ff)
			2'h0: lvl = `UFC_TRIG_SEL0;
			2'h1: lvl = `UFC_TRIG_SEL1;
			2'h2: lvl = `UFC_TRIG_SEL2;
			default: lvl = `UFC_TRIG_SEL3;
		endcase
	end

	// a control write with the enable low changes only the enable; flush beats push/pop
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			en_ff <= 1'b0;
			mode_ff <= 1'b0;
			sel_ff <= 1'b0;
			trig_ff <= 2'h0;
			txc_ff <= 5'h00;
			rxc_ff <= 5'h00;
			d_en_ff <= 1'b0;
			d_m1_ff <= 1'b0;
			d_sel_ff <= 1'b0;
			d_lvl_ff <= `UFC_TRIG_SEL0;
		end else if (ce_i) begin
			// outputs launched at a control write still use the old settings,
			// so the checks compare against these one-edge-late copies
			d_en_ff <= en_ff;
			d_m1_ff <= m1;
			d_sel_ff <= sel_ff;
			d_lvl_ff <= lvl;
			if (fc_wr) begin
				en_ff <= wdata_i[0];
				if (wdata_i[0]) begin
					mode_ff <= wdata_i[3];
					trig_ff <= wdata_i[7:6];
				end
			end
			if (wr_i && addr_i == `UFC_OFS_ALT_FUNC)
				sel_ff <= wdata_i[2:1] == `UFC_AF_MF_RX_DMA_REQUEST;
			txc_ff <= fl_tx ? 5'h00 : txc_ff + {4'h0, t_in} - {4'h0, t_out};
			rxc_ff <= fl_rx ? 5'h00 : rxc_ff + {4'h0, r_in} - {4'h0, r_out};
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not idle");
	a_ctrl_readback: assert property ($past(fc_wr) == 1'b0 && $past(rd_i && addr_i == 4'h2)
		|-> rdata_o == {trig_ff, 2'h0, mode_ff, 2'h0, en_ff}) else $error("control readback");
	a_tx_fill: assert property (tx_valid_o == (txc_ff != 5'h00))
		else $error("tx fill mismatch");
	a_tx_request: assert property (tx_dma_request_n_o ==
		(d_m1_ff ? txc_ff == 5'h10 : txc_ff != 5'h00)) else $error("tx request wrong");
	a_rx_trigger: assert property (rx_trigger_o ==
		(d_en_ff ? rxc_ff >= d_lvl_ff : rxc_ff != 5'h00)) else $error("rx trigger wrong");
	a_pin_unselected: assert property (!d_sel_ff |-> multi_function_pin_o)
		else $error("pin active while unselected");
	a_pin_mode_zero: assert property (d_sel_ff && !d_m1_ff |->
		multi_function_pin_o == (rxc_ff == 5'h00)) else $error("mode 0 rx request wrong");
	a_pin_level_set: assert property (d_sel_ff && d_m1_ff && rxc_ff >= d_lvl_ff
		|-> !multi_function_pin_o) else $error("mode 1 rx request missing at level");
	a_pin_timeout_set: assert property (d_sel_ff && d_m1_ff && $past(rx_timeout_i)
		&& rxc_ff != 5'h00 |-> !multi_function_pin_o)
		else $error("mode 1 rx request missing on timeout");
	a_pin_empty_clear: assert property (d_sel_ff && d_m1_ff && rxc_ff == 5'h00
		|-> multi_function_pin_o) else $error("mode 1 rx request kept when empty");
	a_pin_hold: assert property (d_sel_ff && d_m1_ff && rxc_ff != 5'h00 && !$past(fc_wr)
		&& !$past(fc_wr, 2) && !$past(multi_function_pin_o) |-> !multi_function_pin_o)
		else $error("rx request dropped");
endmodule // ufc_top_checker
